// >>> ncd_clk_div.sv
// Programmable divider clocked by clk, advanced by PLL tick pulses.
// Assumes core_tick and sec_tick are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
module ncd_clk_div (
  input wire logic clk,
  input wire logic nrst,
  input wire logic dis,
  input wire logic sel_sec,
  input wire logic [15:0] div_x,
  input wire logic core_tick,
  input wire logic sec_tick,
  output logic clk_out
);
  logic [15:0] cnt_q;
  logic out_q;
  logic tick;
  logic wrap;

  assign tick = sel_sec ? sec_tick : core_tick;
  assign wrap = (cnt_q >= div_x);
  assign clk_out = out_q;

  // Half period of X+1 ticks gives a full period of 2(X+1)
  always_ff @(posedge clk) begin
    if (!nrst || dis) begin
      cnt_q <= 16'h0000;
      out_q <= 1'b0;
    end else if (tick && wrap) begin
      cnt_q <= 16'h0000;
      out_q <= ~out_q;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule // ncd_clk_div

// >>> ncd_link_bank.sv
// Bank of per-link status, direction and network registers.
// Assumes status inputs are live levels from the switch, synchronous to clk.
`timescale 1ns/1ps
module ncd_link_bank #(
  parameter int N = 8,
  parameter bit HAS_DIR = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [2:0] idx,
  input wire logic [31:0] wdata,
  input wire logic [2*N-1:0] target_type,
  input wire logic [8*N-1:0] dest_link,
  input wire logic [N-1:0] junk,
  input wire logic [N-1:0] dst_busy,
  input wire logic [N-1:0] src_busy,
  output logic [31:0] rdata,
  output logic [4*N-1:0] direction,
  output logic [2*N-1:0] network
);
  logic [3:0] dir_q [N];
  logic [1:0] net_q [N];
  logic [3:0] dir_rd;

  if (N != 8) begin : g_chk
    $error("ncd_link_bank serves exactly eight links");
  end

  assign dir_rd = HAS_DIR ? dir_q[idx] : 4'h0;
  assign rdata = ncd_pkg::status_word(target_type[2*idx +: 2], dest_link[8*idx +: 8], dir_rd,
                                      net_q[idx], junk[idx], dst_busy[idx], src_busy[idx]);

  for (genvar i = 0; i < N; i++) begin : g_link
    assign direction[4*i +: 4] = dir_q[i];
    assign network[2*i +: 2] = net_q[i];
    always_ff @(posedge clk) begin
      if (!nrst) begin
        dir_q[i] <= ncd_pkg::RST_DIR;
        net_q[i] <= ncd_pkg::RST_NET;
      end else if (wr_en && idx == 3'(i)) begin
        dir_q[i] <= HAS_DIR ? wdata[ncd_pkg::POS_DIR_LO +: 4] : ncd_pkg::RST_DIR;
        net_q[i] <= wdata[ncd_pkg::POS_NET_LO +: 2];
      end
    end
  end
endmodule // ncd_link_bank

// >>> ncd_node_cfg.sv
// Node configuration register bank: memory-controller pads, camera clock
// dividers, debug-event source and link status for sixteen links.
// Assumes a plain register port with word indices and inputs synchronous to clk.
//
// Functional notes
// - Config bit 0 set connects the memory controller to its pads.
// - Config bit 1 picks which processor tile reaches the memory controller.
// - Shim divider uses secondary PLL when bit 31 set, core PLL otherwise.
// - Shim divider disabled while bit 16 is one, its reset value.
// - Shim divider outputs input over 2(X+1); X resets to three.
// - PHY divider source select bit 31, secondary when set, resets to one.
// - PHY divider disabled while bit 16 is one, its reset value.
// - PHY divider outputs input over 2(X+1); X resets to zero.
// - Debug source register holds requester of latest debug event.
// - Debug source bit 4 marks the external pin as cause.
// - Debug source bits 1 and 0 mark second and first tile.
// - Eight switch-link registers start at index 0x20.
// - Bits 25:24 report current target type of each link.
// - Bits 23:16 report destination link number while in use.
// - Bits 11:8 of switch-link registers hold writable direction, reset zero.
// - Bits 5:4 hold writable network number, reset zero.
// - Bit 2 reads one while current packet is junk.
// - Bit 1 shows destination side busy, bit 0 source side busy.
// - Eight processor-link registers at 0x40 to 0x47, no direction field.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module ncd_node_cfg (
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // PLL ticks
  input wire logic core_pll_tick,
  input wire logic sec_pll_tick,
  // Debug requesters
  input wire logic dbg_evt_tile0,
  input wire logic dbg_evt_tile1,
  input wire logic dbg_evt_pad,
  // Switch-link status
  input wire logic [15:0] sl_target_type,
  input wire logic [63:0] sl_dest_link,
  input wire logic [7:0] sl_junk,
  input wire logic [7:0] sl_dst_busy,
  input wire logic [7:0] sl_src_busy,
  // Processor-link status
  input wire logic [15:0] pl_target_type,
  input wire logic [63:0] pl_dest_link,
  input wire logic [7:0] pl_junk,
  input wire logic [7:0] pl_dst_busy,
  input wire logic [7:0] pl_src_busy,
  // Memory-controller pad and mux control
  output logic mem_pad_en,
  output logic mem_tile_sel,
  // Divided clocks
  output logic shim_clk,
  output logic phy_clk,
  // Link configuration
  output logic [31:0] sl_direction,
  output logic [15:0] sl_network,
  output logic [15:0] pl_network
);

  // ************************************************************
  // Address decode
  // ************************************************************
  logic hit_mem;
  logic hit_shim;
  logic hit_phy;
  logic hit_dbg;
  logic hit_sl;
  logic hit_pl;
  logic [2:0] link_idx;

  assign hit_mem = (reg_addr == ncd_pkg::OFF_MEM_CFG);
  assign hit_shim = (reg_addr == ncd_pkg::OFF_SHIM_CLK);
  assign hit_phy = (reg_addr == ncd_pkg::OFF_PHY_CLK);
  assign hit_dbg = (reg_addr == ncd_pkg::OFF_DBG_SRC);
  assign hit_sl = (reg_addr[7:3] == ncd_pkg::OFF_SWITCH_LINK_STATUS_BASE[7:3]);
  assign hit_pl = (reg_addr[7:3] == ncd_pkg::OFF_PROCESSOR_LINK_STATUS_BASE[7:3]);
  assign link_idx = reg_addr[2:0];

  // ************************************************************
  // Write strobes
  // ************************************************************
  logic wr_mem;
  logic wr_shim;
  logic wr_phy;
  logic wr_dbg;
  logic wr_sl;
  logic wr_pl;

  assign wr_mem = reg_wr && hit_mem;
  assign wr_shim = reg_wr && hit_shim;
  assign wr_phy = reg_wr && hit_phy;
  assign wr_dbg = reg_wr && hit_dbg;
  assign wr_sl = reg_wr && hit_sl;
  assign wr_pl = reg_wr && hit_pl;

  // ************************************************************
  // Memory-controller configuration
  // ************************************************************
  logic pad_en_q;
  logic pad_en_d;
  logic tile_sel_q;
  logic tile_sel_d;

  assign pad_en_d = wr_mem ? reg_wdata[ncd_pkg::POS_PAD_EN] : pad_en_q;
  assign tile_sel_d = wr_mem ? reg_wdata[ncd_pkg::POS_TILE_SEL] : tile_sel_q;

  // Controller starts isolated from its pads
  // Tile select only matters once the pads are connected
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pad_en_q <= ncd_pkg::RST_PAD_EN;
      tile_sel_q <= ncd_pkg::RST_TILE_SEL;
    end else begin
      pad_en_q <= pad_en_d;
      tile_sel_q <= tile_sel_d;
    end
  end

  assign mem_pad_en = pad_en_q;
  assign mem_tile_sel = tile_sel_q;

  // ************************************************************
  // Camera-shim clock divider register
  // ************************************************************
  logic shim_sec_q;
  logic shim_sec_d;
  logic shim_dis_q;
  logic shim_dis_d;
  logic [15:0] shim_div_q;
  logic [15:0] shim_div_d;

  assign shim_sec_d = wr_shim ? reg_wdata[ncd_pkg::POS_SRC_SEC] : shim_sec_q;
  assign shim_dis_d = wr_shim ? reg_wdata[ncd_pkg::POS_DIV_DIS] : shim_dis_q;
  assign shim_div_d = wr_shim ? reg_wdata[15:0] : shim_div_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      shim_sec_q <= ncd_pkg::RST_SHIM_SRC_SEC;
      shim_dis_q <= ncd_pkg::RST_SHIM_DIS;
      shim_div_q <= ncd_pkg::RST_SHIM_DIV;
    end else begin
      shim_sec_q <= shim_sec_d;
      shim_dis_q <= shim_dis_d;
      shim_div_q <= shim_div_d;
    end
  end

  // ************************************************************
  // Camera-PHY clock divider register
  // ************************************************************
  logic phy_sec_q;
  logic phy_sec_d;
  logic phy_dis_q;
  logic phy_dis_d;
  logic [15:0] phy_div_q;
  logic [15:0] phy_div_d;

  assign phy_sec_d = wr_phy ? reg_wdata[ncd_pkg::POS_SRC_SEC] : phy_sec_q;
  assign phy_dis_d = wr_phy ? reg_wdata[ncd_pkg::POS_DIV_DIS] : phy_dis_q;
  assign phy_div_d = wr_phy ? reg_wdata[15:0] : phy_div_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phy_sec_q <= ncd_pkg::RST_PHY_SRC_SEC;
      phy_dis_q <= ncd_pkg::RST_PHY_DIS;
      phy_div_q <= ncd_pkg::RST_PHY_DIV;
    end else begin
      phy_sec_q <= phy_sec_d;
      phy_dis_q <= phy_dis_d;
      phy_div_q <= phy_div_d;
    end
  end

  // ************************************************************
  // Divider instances
  // ************************************************************
  // Changing the divide value mid-run applies to the current half period;
  // a smaller value wraps at once since the count compares with >=.
  // shim divider
  ncd_clk_div u_shim_div (
    .clk(clk),
    .nrst(nrst),
    .dis(shim_dis_q),
    .sel_sec(shim_sec_q),
    .div_x(shim_div_q),
    .core_tick(core_pll_tick),
    .sec_tick(sec_pll_tick),
    .clk_out(shim_clk)
  );

  ncd_clk_div u_phy_div (
    .clk(clk),
    .nrst(nrst),
    .dis(phy_dis_q),
    .sel_sec(phy_sec_q),
    .div_x(phy_div_q),
    .core_tick(core_pll_tick),
    .sec_tick(sec_pll_tick),
    .clk_out(phy_clk)
  );

  // ************************************************************
  // Debug-event source
  // ************************************************************
  logic [2:0] dbg_src_q;
  logic [2:0] dbg_src_d;
  logic dbg_evt;
  logic [2:0] dbg_evt_vec;
  logic [2:0] dbg_wr_vec;

  assign dbg_evt_vec = {dbg_evt_pad, dbg_evt_tile1, dbg_evt_tile0};
  assign dbg_evt = |dbg_evt_vec;
  assign dbg_wr_vec = {reg_wdata[ncd_pkg::POS_DBG_PAD], reg_wdata[ncd_pkg::POS_DBG_T1],
                       reg_wdata[ncd_pkg::POS_DBG_T0]};

  // tile and pad source bits
  // Event beats a same-cycle software write so no cause is lost
  // Software may clear the record by writing zeros between events
  assign dbg_src_d = dbg_evt ? dbg_evt_vec : (wr_dbg ? dbg_wr_vec : dbg_src_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dbg_src_q <= ncd_pkg::RST_DBG_SRC;
    end else begin
      dbg_src_q <= dbg_src_d;
    end
  end

  // ************************************************************
  // Link register banks
  // ************************************************************
  logic [31:0] sl_rdata;
  logic [31:0] pl_rdata;

  ncd_link_bank #(
    .N(8),
    .HAS_DIR(1'b1)
  ) u_sl_bank (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_sl),
    .idx(link_idx),
    .wdata(reg_wdata),
    .target_type(sl_target_type),
    .dest_link(sl_dest_link),
    .junk(sl_junk),
    .dst_busy(sl_dst_busy),
    .src_busy(sl_src_busy),
    .rdata(sl_rdata),
    .direction(sl_direction),
    .network(sl_network)
  );

  ncd_link_bank #(
    .N(8),
    .HAS_DIR(1'b0)
  ) u_pl_bank (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_pl),
    .idx(link_idx),
    .wdata(reg_wdata),
    .target_type(pl_target_type),
    .dest_link(pl_dest_link),
    .junk(pl_junk),
    .dst_busy(pl_dst_busy),
    .src_busy(pl_src_busy),
    .rdata(pl_rdata),
    .direction(),
    .network(pl_network)
  );

  // ************************************************************
  // Read path
  // ************************************************************
  logic [31:0] mem_word;
  logic [31:0] shim_word;
  logic [31:0] phy_word;
  logic [31:0] dbg_word;
  logic [31:0] rd_sel;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // reserved bits zero
  // Link status is live: a read shows the inputs of the read cycle,
  // so software must not expect two reads to agree while traffic flows.
  assign mem_word = {30'h0, tile_sel_q, pad_en_q};
  assign shim_word = {shim_sec_q, 14'h0, shim_dis_q, shim_div_q};
  assign phy_word = {phy_sec_q, 14'h0, phy_dis_q, phy_div_q};
  assign dbg_word = {27'h0, dbg_src_q[2], 2'h0, dbg_src_q[1:0]};

  // Unmapped indices read as zero
  assign rd_sel = hit_mem ? mem_word :
                  hit_shim ? shim_word :
                  hit_phy ? phy_word :
                  hit_dbg ? dbg_word :
                  hit_sl ? sl_rdata :
                  hit_pl ? pl_rdata :
                  32'h0000_0000;

  // Data stands for one cycle only, zero otherwise
  assign rdata_d = reg_rd ? rd_sel : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // ncd_node_cfg

// >>> ncd_node_cfg_sva.sv
// Checker for the node configuration register bank.
// Assumes it is bound to ncd_node_cfg and that every port lives on clk.
`timescale 1ns/1ps
module ncd_node_cfg_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic dbg_evt_tile0,
  input wire logic dbg_evt_tile1,
  input wire logic dbg_evt_pad,
  input wire logic [15:0] sl_target_type,
  input wire logic [63:0] sl_dest_link,
  input wire logic [7:0] pl_junk,
  input wire logic [7:0] pl_dst_busy,
  input wire logic [7:0] pl_src_busy,
  input wire logic mem_pad_en,
  input wire logic mem_tile_sel,
  input wire logic shim_clk,
  input wire logic [31:0] sl_direction,
  input wire logic [15:0] pl_network
);
  // ****************
  // Helpers
  // ****************
  logic [2:0] wi_q;
  wire logic sl_hit = reg_addr[7:3] == 5'h04;
  wire logic pl_hit = reg_addr[7:3] == 5'h08;
  wire logic mem_wr = reg_wr && reg_addr == ncd_pkg::OFF_MEM_CFG;
  wire logic any_evt = dbg_evt_pad || dbg_evt_tile1 || dbg_evt_tile0;

  // Link index of the previous access, for write checks
  always_ff @(posedge clk) begin
    wi_q <= reg_addr[2:0];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ****************
  // Properties
  // ****************
  property p_pad_en;
    mem_wr |=> mem_pad_en == $past(reg_wdata[0]);
  endproperty
  a_pad_en: assert property (p_pad_en) else $error("pad enable differs from written bit");

  property p_tile_sel;
    mem_wr |=> mem_tile_sel == $past(reg_wdata[1]);
  endproperty
  a_tile_sel: assert property (p_tile_sel) else $error("tile select differs from written bit");

  property p_mem_hold;
    !mem_wr |=> $stable(mem_pad_en) && $stable(mem_tile_sel);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory control moved without a write");

  property p_dbg;
    reg_rd && reg_addr == ncd_pkg::OFF_DBG_SRC && !any_evt && $past(any_evt)
      |=> reg_rdata[4:0] == {$past(dbg_evt_pad, 2), 2'b00, $past(dbg_evt_tile1, 2), $past(dbg_evt_tile0, 2)};
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug source does not show last event");

  property p_sl_rd;
    reg_rd && sl_hit |=> reg_rdata[25:16] ==
      {$past(sl_target_type[2*reg_addr[2:0] +: 2]), $past(sl_dest_link[8*reg_addr[2:0] +: 8])};
  endproperty
  a_sl_rd: assert property (p_sl_rd) else $error("switch link type or destination wrong");

  property p_pl_rd;
    reg_rd && pl_hit |=> reg_rdata[11:8] == 4'h0 && reg_rdata[2:0] ==
      $past({pl_junk[reg_addr[2:0]], pl_dst_busy[reg_addr[2:0]], pl_src_busy[reg_addr[2:0]]});
  endproperty
  a_pl_rd: assert property (p_pl_rd) else $error("processor link flags wrong");

  property p_rsv;
    reg_rd && (sl_hit || pl_hit)
      |=> reg_rdata[31:26] == 6'h00 && reg_rdata[15:12] == 4'h0 && reg_rdata[7:6] == 2'h0 && !reg_rdata[3];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved link bits not zero");

  property p_dir;
    reg_wr && sl_hit |=> sl_direction[4*wi_q +: 4] == $past(reg_wdata[11:8]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction output not updated");

  property p_net;
    reg_wr && pl_hit |=> pl_network[2*wi_q +: 2] == $past(reg_wdata[5:4]);
  endproperty
  a_net: assert property (p_net) else $error("network output not updated");

  // Divider still sees the old enable on the write edge and may toggle once;
  // two cycles only after that, since a later re-enable may legally toggle again
  property p_shim_off;
    reg_wr && reg_addr == ncd_pkg::OFF_SHIM_CLK && reg_wdata[16] |=> ##1 !shim_clk [*2];
  endproperty
  a_shim_off: assert property (p_shim_off) else $error("shim clock not held low");

  c_link_wr: cover property (reg_wr && sl_hit);
  c_dbg_rd: cover property (reg_rd && reg_addr == ncd_pkg::OFF_DBG_SRC && $past(any_evt));
  c_shim_rise: cover property ($rose(shim_clk));
endmodule // ncd_node_cfg_sva

bind ncd_node_cfg ncd_node_cfg_sva ncd_node_cfg_sva_inst (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dbg_evt_tile0(dbg_evt_tile0), .dbg_evt_tile1(dbg_evt_tile1), .dbg_evt_pad(dbg_evt_pad),
  .sl_target_type(sl_target_type), .sl_dest_link(sl_dest_link), .pl_junk(pl_junk), .pl_dst_busy(pl_dst_busy),
  .pl_src_busy(pl_src_busy), .mem_pad_en(mem_pad_en), .mem_tile_sel(mem_tile_sel), .shim_clk(shim_clk),
  .sl_direction(sl_direction), .pl_network(pl_network)
);

// >>> ncd_pkg.sv
// Constants shared by the node configuration register bank.
// Assumes a word-indexed register port; indices are printed offsets.
package ncd_pkg;

  // ************************************************************
  // Register indices
  // ************************************************************
  localparam logic [7:0] OFF_MEM_CFG = 8'h13;
  localparam logic [7:0] OFF_SHIM_CLK = 8'h14;
  localparam logic [7:0] OFF_PHY_CLK = 8'h15;
  localparam logic [7:0] OFF_DBG_SRC = 8'h1f;
  localparam logic [7:0] OFF_SWITCH_LINK_STATUS_BASE = 8'h20;
  localparam logic [7:0] OFF_PROCESSOR_LINK_STATUS_BASE = 8'h40;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int POS_PAD_EN = 0;
  localparam int POS_TILE_SEL = 1;
  localparam int POS_SRC_SEC = 31;
  localparam int POS_DIV_DIS = 16;
  localparam int POS_DBG_PAD = 4;
  localparam int POS_DBG_T1 = 1;
  localparam int POS_DBG_T0 = 0;
  localparam int POS_TYPE_LO = 24;
  localparam int POS_DEST_LO = 16;
  localparam int POS_DIR_LO = 8;
  localparam int POS_NET_LO = 4;
  localparam int POS_JUNK = 2;
  localparam int POS_DST_BUSY = 1;
  localparam int POS_SRC_BUSY = 0;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic RST_PAD_EN = 1'b0;
  localparam logic RST_TILE_SEL = 1'b0;
  localparam logic [2:0] RST_DBG_SRC = 3'h0;
  localparam logic RST_SHIM_SRC_SEC = 1'b0;
  localparam logic RST_SHIM_DIS = 1'b1;
  localparam logic [15:0] RST_SHIM_DIV = 16'h0003;
  localparam logic RST_PHY_SRC_SEC = 1'b1;
  localparam logic RST_PHY_DIS = 1'b1;
  localparam logic [15:0] RST_PHY_DIV = 16'h0000;
  localparam logic [3:0] RST_DIR = 4'h0;
  localparam logic [1:0] RST_NET = 2'h0;

  // Link status word; reserved bits stay zero
  function automatic logic [31:0] status_word(input logic [1:0] typ, input logic [7:0] dest,
                                              input logic [3:0] dir, input logic [1:0] net,
                                              input logic junk, input logic dbusy, input logic sbusy);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[POS_TYPE_LO +: 2] = typ;
    w[POS_DEST_LO +: 8] = dest;
    w[POS_DIR_LO +: 4] = dir;
    w[POS_NET_LO +: 2] = net;
    w[POS_JUNK] = junk;
    w[POS_DST_BUSY] = dbusy;
    w[POS_SRC_BUSY] = sbusy;
    return w;
  endfunction

endpackage

// >>> testbench.sv
// Self-checking bench for the node configuration register bank.
// Assumes ncd_pkg, the design and the bound checker are compiled before it.
`timescale 1ns/1ps
module testbench;
  logic clk, nrst, reg_wr, reg_rd, core_pll_tick, dbg_evt_tile0, dbg_evt_tile1, dbg_evt_pad;
  logic mem_pad_en, mem_tile_sel, shim_clk, phy_clk;
  logic sec_pll_tick = 1'b0;
  logic [1:0] tk = 2'h0;
  logic [7:0] reg_addr, sl_junk, sl_dst_busy, sl_src_busy, pl_junk, pl_dst_busy, pl_src_busy;
  logic [31:0] reg_wdata, reg_rdata, sl_direction, dexp, d;
  logic [15:0] sl_target_type, pl_target_type, sl_network, pl_network;
  logic [63:0] sl_dest_link, pl_dest_link;
  int failures = 0;
  int n_checks = 0;

  ncd_node_cfg ncd_node_cfg_inst (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_pll_tick(core_pll_tick), .sec_pll_tick(sec_pll_tick),
    .dbg_evt_tile0(dbg_evt_tile0), .dbg_evt_tile1(dbg_evt_tile1), .dbg_evt_pad(dbg_evt_pad),
    .sl_target_type(sl_target_type), .sl_dest_link(sl_dest_link), .sl_junk(sl_junk),
    .sl_dst_busy(sl_dst_busy), .sl_src_busy(sl_src_busy), .pl_target_type(pl_target_type),
    .pl_dest_link(pl_dest_link), .pl_junk(pl_junk), .pl_dst_busy(pl_dst_busy), .pl_src_busy(pl_src_busy),
    .mem_pad_en(mem_pad_en), .mem_tile_sel(mem_tile_sel), .shim_clk(shim_clk), .phy_clk(phy_clk),
    .sl_direction(sl_direction), .sl_network(sl_network), .pl_network(pl_network)
  );

  // ****************
  // Stimulus
  // ****************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Secondary ticks every third cycle, so a wrong source shows in the period
  always @(posedge clk) begin
    tk <= (tk == 2'h2) ? 2'h0 : tk + 2'h1;
    sec_pll_tick <= tk == 2'h2;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict;
  end

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  // Pulse events, then read the source register in the very next cycle
  task automatic dbg(input logic [2:0] v, input logic [31:0] e);
    @(posedge clk);
    {dbg_evt_pad, dbg_evt_tile1, dbg_evt_tile0} <= v;
    @(posedge clk);
    {dbg_evt_pad, dbg_evt_tile1, dbg_evt_tile0} <= 3'b000;
    reg_rd <= 1'b1;
    reg_addr <= ncd_pkg::OFF_DBG_SRC;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  // Rise-to-rise period in clk cycles; the time up to the first rise is skipped
  task automatic period(input logic phy, input int exp);
    int n;
    int t;
    t = 0;
    for (int k = 0; k < 4; k++) begin
      n = 0;
      while (((phy ? phy_clk : shim_clk) !== k[0]) && n < 100) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (k > 1) begin
        t += n;
      end
    end
    chk(32'(t), 32'(exp));
  endtask

  task automatic low(input logic phy);
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(posedge clk);
      #1 seen = seen | (phy ? phy_clk : shim_clk);
    end
    chk(32'(seen), 32'h0);
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************
  // Tests
  // ****************
  initial begin
    {nrst, reg_wr, reg_rd, core_pll_tick, dbg_evt_tile0, dbg_evt_tile1, dbg_evt_pad} = 7'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    {sl_junk, sl_dst_busy, sl_src_busy} = 24'h55_33_0f;
    {pl_junk, pl_dst_busy, pl_src_busy} = 24'haa_cc_f0;
    dexp = 32'h0;
    for (int i = 0; i < 8; i++) begin
      sl_target_type[2*i +: 2] = 2'(i);
      sl_dest_link[8*i +: 8] = 8'ha0 + 8'(i);
      pl_target_type[2*i +: 2] = 2'(i + 1);
      pl_dest_link[8*i +: 8] = 8'h50 + 8'(i);
    end
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    core_pll_tick <= 1'b1;
    rd(ncd_pkg::OFF_MEM_CFG, 32'h0);
    rd(ncd_pkg::OFF_SHIM_CLK, 32'h0001_0003);
    rd(ncd_pkg::OFF_PHY_CLK, 32'h8001_0000);
    rd(ncd_pkg::OFF_DBG_SRC, 32'h0);
    low(1'b0);
    low(1'b1);
    chk(sl_direction, 32'h0);
    chk({sl_network, pl_network}, 32'h0);
    wr(ncd_pkg::OFF_MEM_CFG, 32'hffff_ffff);
    chk({30'h0, mem_tile_sel, mem_pad_en}, 32'h3);
    rd(ncd_pkg::OFF_MEM_CFG, 32'h3);
    wr(ncd_pkg::OFF_MEM_CFG, 32'h2);
    chk({30'h0, mem_tile_sel, mem_pad_en}, 32'h2);
    wr(ncd_pkg::OFF_MEM_CFG, 32'h1);
    chk({30'h0, mem_tile_sel, mem_pad_en}, 32'h1);
    // Divider source, enable and ratio
    wr(ncd_pkg::OFF_SHIM_CLK, 32'hfffe_0001);
    rd(ncd_pkg::OFF_SHIM_CLK, 32'h8000_0001);
    period(1'b0, 12);
    wr(ncd_pkg::OFF_SHIM_CLK, 32'h0001_0003);
    low(1'b0);
    wr(ncd_pkg::OFF_SHIM_CLK, 32'h0000_0003);
    period(1'b0, 8);
    wr(ncd_pkg::OFF_PHY_CLK, 32'h8000_0002);
    period(1'b1, 18);
    wr(ncd_pkg::OFF_PHY_CLK, 32'h7fff_ffff);
    rd(ncd_pkg::OFF_PHY_CLK, 32'h0001_ffff);
    low(1'b1);
    wr(ncd_pkg::OFF_PHY_CLK, 32'h0000_0000);
    period(1'b1, 2);
    // Debug event source
    dbg(3'b010, 32'h2);
    dbg(3'b101, 32'h11);
    dbg(3'b001, 32'h1);
    wr(ncd_pkg::OFF_DBG_SRC, 32'hffff_ffff);
    rd(ncd_pkg::OFF_DBG_SRC, 32'h13);
    // Link registers, all four target types and networks
    for (int i = 0; i < 8; i++) begin
      d = 32'hffff_f0cf | (32'(i + 1) << 8) | (32'(i % 4) << 4);
      dexp[4*i +: 4] = 4'(i + 1);
      wr(ncd_pkg::OFF_SWITCH_LINK_STATUS_BASE + 8'(i), d);
      rd(ncd_pkg::OFF_SWITCH_LINK_STATUS_BASE + 8'(i), {6'h0, 2'(i), 8'ha0 + 8'(i), 4'h0, 4'(i + 1), 2'h0, 2'(i), 1'b0,
         sl_junk[i], sl_dst_busy[i], sl_src_busy[i]});
      wr(ncd_pkg::OFF_PROCESSOR_LINK_STATUS_BASE + 8'(i), d);
      rd(ncd_pkg::OFF_PROCESSOR_LINK_STATUS_BASE + 8'(i), {6'h0, 2'(i + 1), 8'h50 + 8'(i), 8'h0, 2'h0, 2'(i), 1'b0,
         pl_junk[i], pl_dst_busy[i], pl_src_busy[i]});
      chk(32'(pl_network[2*i +: 2]), 32'(i % 4));
      chk(32'(sl_network[2*i +: 2]), 32'(i % 4));
    end
    wr(8'h28, 32'hffff_ffff);
    rd(8'h28, 32'h0);
    wr(8'h48, 32'hffff_ffff);
    rd(8'h48, 32'h0);
    chk(sl_direction, dexp);
    give_verdict;
  end
endmodule // testbench
